/* File: logic/esf_buf2.sv */
// two-entry buffer on the read data path
`default_nettype none
module esf_buf2 (
  input  wire logic             clk,
  input  wire logic             rst_n,
  esf_stream_if.snk             in_s,
  esf_stream_if.src             out_s,
  output logic [1:0]            lvl
);
  typedef struct packed {
    logic [17:0] d0;
    logic [17:0] d1;
    logic [1:0]  cnt;
  } esf_buf_st_t;

  esf_buf_st_t st_reg;
  esf_buf_st_t st_next;
  logic        push;
  logic        pop;

  assign in_s.ready  = (st_reg.cnt != esf_pkg::BUF_DEPTH);
  assign out_s.valid = (st_reg.cnt != 2'h0);
  assign out_s.data  = st_reg.d0;
  assign lvl         = st_reg.cnt;
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // head always in d0 so the output is a flop
  always_comb begin
    st_next = st_reg;
    if (pop) begin
      st_next.d0 = st_reg.d1;
    end
    if (push) begin
      if (st_reg.cnt == 2'h0 || (st_reg.cnt == 2'h1 && pop)) begin
        st_next.d0 = in_s.data;
      end else begin
        st_next.d1 = in_s.data;
      end
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_buf_hold_stall: assert property (@(posedge clk) disable iff (!rst_n)
    out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data))
    else $error("buffer head changed while stalled");
endmodule
`default_nettype wire

/* File: logic/esf_fifo_top.sv */
// embedded dual-port sram block with built-in fifo controller
// Behaviour
// - one block stores 4608 bits; the x1, x2 and x4 aspects reach only 4096 of them.
// - aspects 256x18, 512x9, 1kx4, 2kx2 and 4kx1 are supported.
// - read and write ports are independent, with their own widths in ram mode.
// - a built-in fifo controller runs the block as a synchronous fifo.
// - fifo word width and depth are set by configuration.
// - near-empty and near-full flags with programmable thresholds.
// - plain empty and full flags are also driven.
// - internal counters generate the read and write pointers.
// - blocks combine side by side or in series for more width or depth.
// - contents can be preloaded through the test path, giving rom use.
//
// The strobed register port and the register offsets were left to the implementer.
`default_nettype none
module esf_fifo_top (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA,
  input  wire logic        WR_EN,
  input  wire logic [11:0] WR_ADDR,
  input  wire logic [17:0] WR_DATA,
  output logic             WR_READY,
  input  wire logic        RD_EN,
  input  wire logic [11:0] RD_ADDR,
  output logic             RD_READY,
  output logic             OUT_VALID,
  input  wire logic        OUT_READY,
  output logic [17:0]      OUT_DATA,
  output logic             EMPTY,
  output logic             FULL,
  output logic             NEAR_EMPTY_FLAG,
  output logic             NEAR_FULL_FLAG
);
  typedef struct packed {
    logic                   fifo_en;
    esf_pkg::esf_width_t    wr_w;
    esf_pkg::esf_width_t    rd_w;
    logic [12:0]            depth;
    logic [12:0]            ae_thr;
    logic [12:0]            af_thr;
    logic [11:0]            wptr;
    logic [11:0]            rptr;
    logic [12:0]            count;
    logic                   ovf;
    logic                   unf;
    logic [7:0]             init_row;
    logic                   pend;
    logic [4:0]             rd_off;
    esf_pkg::esf_width_t    rd_lw;
    logic [31:0]            rdata;
  } esf_ctl_st_t;

  esf_ctl_st_t st_reg;
  esf_ctl_st_t st_next;

  // storage: 256 rows of 18 bits, every aspect maps onto it
  logic [17:0] mem [0:255];
  logic [17:0] row_q;

  esf_stream_if rd_s ();
  esf_stream_if out_s ();
  logic [1:0]   buf_lvl;

  // row of a word for a given aspect
  function automatic logic [7:0] row_of(input esf_pkg::esf_width_t w, input logic [11:0] a);
    case (w)
      esf_pkg::ESF_W1: row_of = a[11:4];
      esf_pkg::ESF_W2: row_of = a[10:3];
      esf_pkg::ESF_W4: row_of = a[9:2];
      esf_pkg::ESF_W9: row_of = a[8:1];
      default:         row_of = a[7:0];
    endcase
  endfunction

  // bit offset in the row; narrow aspects skip the two ninth bits
  function automatic logic [4:0] off_of(input esf_pkg::esf_width_t w, input logic [11:0] a);
    logic [4:0] o;
    case (w)
      esf_pkg::ESF_W1: o = {1'b0, a[3:0]};
      esf_pkg::ESF_W2: o = {1'b0, a[2:0], 1'b0};
      esf_pkg::ESF_W4: o = {1'b0, a[1:0], 2'h0};
      esf_pkg::ESF_W9: o = a[0] ? 5'h09 : 5'h00;
      default:         o = 5'h00;
    endcase
    if (w == esf_pkg::ESF_W1 || w == esf_pkg::ESF_W2 || w == esf_pkg::ESF_W4) begin
      o = o + {4'h0, o[3]};
    end
    off_of = o;
  endfunction

  function automatic logic [17:0] mask_of(input esf_pkg::esf_width_t w);
    case (w)
      esf_pkg::ESF_W1: mask_of = 18'h00001;
      esf_pkg::ESF_W2: mask_of = 18'h00003;
      esf_pkg::ESF_W4: mask_of = 18'h0000f;
      esf_pkg::ESF_W9: mask_of = 18'h001ff;
      default:         mask_of = 18'h3ffff;
    endcase
  endfunction

  // words of capacity for an aspect
  function automatic logic [12:0] cap_of(input esf_pkg::esf_width_t w);
    case (w)
      esf_pkg::ESF_W1: cap_of = 13'h1000;
      esf_pkg::ESF_W2: cap_of = 13'h0800;
      esf_pkg::ESF_W4: cap_of = 13'h0400;
      esf_pkg::ESF_W9: cap_of = 13'h0200;
      default:         cap_of = 13'h0100;
    endcase
  endfunction

  function automatic logic [4:0] bits_of(input esf_pkg::esf_width_t w);
    case (w)
      esf_pkg::ESF_W1: bits_of = 5'h01;
      esf_pkg::ESF_W2: bits_of = 5'h02;
      esf_pkg::ESF_W4: bits_of = 5'h04;
      esf_pkg::ESF_W9: bits_of = 5'h09;
      default:         bits_of = 5'h12;
    endcase
  endfunction

  esf_pkg::esf_width_t rd_w_eff;
  logic [12:0] eff_depth;
  logic        preload;
  logic        wr_take;
  logic        rd_take;
  logic        out_fire;
  logic [2:0]  rd_room;
  logic [11:0] wa;
  logic [11:0] ra;
  logic [7:0]  w_row;
  logic [17:0] w_mask;
  logic [17:0] w_data;
  logic [7:0]  r_row;
  logic        full_c;
  logic        empty_c;

  // fifo mode reads at the write aspect so words pair one to one
  assign rd_w_eff = st_reg.fifo_en ? st_reg.wr_w : st_reg.rd_w;
  // configured depth clipped to what the aspect holds
  assign eff_depth = (st_reg.depth == 13'h0000) ? 13'h0001 :
                     (st_reg.depth > cap_of(st_reg.wr_w)) ? cap_of(st_reg.wr_w) : st_reg.depth;
  assign full_c  = st_reg.fifo_en && (st_reg.count >= eff_depth);
  assign empty_c = (st_reg.count == 13'h0000);

  // preload owns the write port for its cycle
  assign preload  = REG_WR && (REG_ADDR == esf_pkg::REG_INIT_DATA);
  assign WR_READY = !preload && !full_c;
  assign wr_take  = WR_EN && WR_READY;
  // room counts the word already in flight so a stall loses nothing
  assign out_fire = OUT_VALID && OUT_READY;
  assign rd_room  = {1'b0, buf_lvl} + {2'h0, st_reg.pend};
  assign RD_READY = (rd_room < {1'b0, esf_pkg::BUF_DEPTH}) || (out_fire && rd_room == {1'b0, esf_pkg::BUF_DEPTH});
  assign rd_take  = RD_EN && RD_READY && !(st_reg.fifo_en && empty_c);

  // pointers replace user addresses in fifo mode
  assign wa     = st_reg.fifo_en ? st_reg.wptr : WR_ADDR;
  assign ra     = st_reg.fifo_en ? st_reg.rptr : RD_ADDR;
  assign w_row  = preload ? st_reg.init_row : row_of(st_reg.wr_w, wa);
  assign w_mask = preload ? 18'h3ffff : (mask_of(st_reg.wr_w) << off_of(st_reg.wr_w, wa));
  assign w_data = preload ? REG_WDATA[17:0] : ((WR_DATA & mask_of(st_reg.wr_w)) << off_of(st_reg.wr_w, wa));
  assign r_row  = row_of(rd_w_eff, ra);

  // array kept free of reset so it maps onto block ram
  always_ff @(posedge CLK) begin
    for (int i = 0; i < 18; i++) begin
      if ((wr_take || preload) && w_mask[i]) begin
        mem[w_row][i] <= w_data[i];
      end
    end
    if (rd_take) begin
      row_q <= mem[r_row];
    end
  end

  // extracted word enters the buffer one cycle after the read
  assign rd_s.valid = st_reg.pend;
  assign rd_s.data  = (row_q >> st_reg.rd_off) & mask_of(st_reg.rd_lw);
  assign out_s.ready = OUT_READY;
  assign OUT_VALID   = out_s.valid;
  assign OUT_DATA    = out_s.data;

  esf_buf2 u_buf (
    .clk   (CLK),
    .rst_n (NRST),
    .in_s  (rd_s),
    .out_s (out_s),
    .lvl   (buf_lvl)
  );

  // controller, configuration and register port
  always_comb begin
    st_next        = st_reg;
    st_next.pend   = rd_take;
    st_next.rd_off = rd_take ? off_of(rd_w_eff, ra) : st_reg.rd_off;
    st_next.rd_lw  = rd_take ? rd_w_eff : st_reg.rd_lw;
    st_next.rdata  = 32'h0000_0000;
    // fifo pointer counters with wrap at the configured depth
    if (st_reg.fifo_en) begin
      if (wr_take) begin
        st_next.wptr = ({1'b0, st_reg.wptr} == eff_depth - 13'h0001) ? 12'h000 : st_reg.wptr + 12'h001;
      end
      if (rd_take) begin
        st_next.rptr = ({1'b0, st_reg.rptr} == eff_depth - 13'h0001) ? 12'h000 : st_reg.rptr + 12'h001;
      end
      st_next.count = st_reg.count + {12'h000, wr_take} - {12'h000, rd_take};
    end
    if (preload) begin
      st_next.init_row = st_reg.init_row + 8'h01;
    end
    // register writes
    if (REG_WR) begin
      case (REG_ADDR)
        esf_pkg::REG_CTRL: begin
          st_next.fifo_en = REG_WDATA[esf_pkg::CTRL_FIFO_BIT];
          st_next.wr_w    = esf_pkg::esf_width_t'(REG_WDATA[esf_pkg::CTRL_WRW_LSB +: 3]);
          st_next.rd_w    = esf_pkg::esf_width_t'(REG_WDATA[esf_pkg::CTRL_RDW_LSB +: 3]);
          if (REG_WDATA[esf_pkg::CTRL_FLUSH_BIT]) begin
            st_next.wptr  = 12'h000;
            st_next.rptr  = 12'h000;
            st_next.count = 13'h0000;
          end
        end
        esf_pkg::REG_DEPTH:     st_next.depth    = REG_WDATA[12:0];
        esf_pkg::REG_AE_THR:    st_next.ae_thr   = REG_WDATA[12:0];
        esf_pkg::REG_AF_THR:    st_next.af_thr   = REG_WDATA[12:0];
        esf_pkg::REG_INIT_ADDR: st_next.init_row = REG_WDATA[7:0];
        esf_pkg::REG_STATUS: begin
          if (REG_WDATA[esf_pkg::ST_OVF]) begin
            st_next.ovf = 1'b0;
          end
          if (REG_WDATA[esf_pkg::ST_UNF]) begin
            st_next.unf = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // writes refused at full and reads refused at empty stick; a new one beats a clear in the same cycle
    if (st_reg.fifo_en && WR_EN && full_c) begin
      st_next.ovf = 1'b1;
    end
    if (st_reg.fifo_en && RD_EN && empty_c) begin
      st_next.unf = 1'b1;
    end
    // read data stands for the one cycle after the strobe only
    if (REG_RD) begin
      case (REG_ADDR)
        esf_pkg::REG_CTRL: begin
          st_next.rdata[esf_pkg::CTRL_FIFO_BIT] = st_reg.fifo_en;
          st_next.rdata[esf_pkg::CTRL_WRW_LSB +: 3] = st_reg.wr_w;
          st_next.rdata[esf_pkg::CTRL_RDW_LSB +: 3] = st_reg.rd_w;
        end
        esf_pkg::REG_DEPTH:     st_next.rdata[12:0] = st_reg.depth;
        esf_pkg::REG_AE_THR:    st_next.rdata[12:0] = st_reg.ae_thr;
        esf_pkg::REG_AF_THR:    st_next.rdata[12:0] = st_reg.af_thr;
        esf_pkg::REG_INIT_ADDR: st_next.rdata[7:0]  = st_reg.init_row;
        esf_pkg::REG_STATUS: begin
          st_next.rdata[esf_pkg::ST_EMPTY]  = EMPTY;
          st_next.rdata[esf_pkg::ST_FULL]   = FULL;
          st_next.rdata[esf_pkg::ST_NEAR_E] = NEAR_EMPTY_FLAG;
          st_next.rdata[esf_pkg::ST_NEAR_F] = NEAR_FULL_FLAG;
          st_next.rdata[esf_pkg::ST_OVF]    = st_reg.ovf;
          st_next.rdata[esf_pkg::ST_UNF]    = st_reg.unf;
          st_next.rdata[esf_pkg::ST_CNT_LSB +: 13] = st_reg.count;
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_reg        <= '0;
      st_reg.wr_w   <= esf_pkg::ESF_W18;
      st_reg.rd_w   <= esf_pkg::ESF_W18;
      st_reg.rd_lw  <= esf_pkg::ESF_W18;
      st_reg.depth  <= esf_pkg::DEPTH_RST;
      st_reg.ae_thr <= esf_pkg::AE_THR_RST;
      st_reg.af_thr <= esf_pkg::AF_THR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // flags purely from the count so paralleled blocks stay in lockstep
  assign EMPTY           = st_reg.fifo_en && empty_c;
  assign FULL            = full_c;
  assign NEAR_EMPTY_FLAG = st_reg.fifo_en && (st_reg.count <= st_reg.ae_thr);
  assign NEAR_FULL_FLAG  = st_reg.fifo_en && (st_reg.count >= st_reg.af_thr);
  assign REG_RDATA       = st_reg.rdata;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  a_full_no_move: assert property (
    st_reg.fifo_en && FULL && WR_EN && !rd_take |=> st_reg.count == $past(st_reg.count) && $stable(st_reg.wptr))
    else $error("write while full changed the fifo");
  a_empty_no_move: assert property (
    st_reg.fifo_en && EMPTY && RD_EN |=> $stable(st_reg.rptr) && !st_reg.pend)
    else $error("read while empty moved the read pointer");
  a_push_counts: assert property (
    st_reg.fifo_en && wr_take && !rd_take && !REG_WR |=> st_reg.count == $past(st_reg.count) + 13'h0001)
    else $error("accepted write not counted");
  a_push_not_empty: assert property (
    st_reg.fifo_en && EMPTY && wr_take && !REG_WR |=> !EMPTY)
    else $error("empty stayed after a write");
  a_near_flags: assert property (
    EMPTY |-> NEAR_EMPTY_FLAG)
    else $error("near-empty low while empty");
  a_near_full_cap: assert property (
    FULL && st_reg.af_thr <= eff_depth |-> NEAR_FULL_FLAG)
    else $error("near-full low while full");
  a_read_latency: assert property (
    rd_take |-> ##2 OUT_VALID)
    else $error("read word missing two cycles later");
  a_cap_bound: assert property (
    eff_depth * bits_of(st_reg.wr_w) <= 18'(esf_pkg::MEM_BITS))
    else $error("depth exceeds block storage");
  a_ptr_range: assert property (
    st_reg.fifo_en && !$past(REG_WR) |-> {1'b0, st_reg.wptr} < eff_depth)
    else $error("write pointer beyond depth");
  a_preload_step: assert property (
    preload |=> st_reg.init_row == $past(st_reg.init_row) + 8'h01)
    else $error("preload row not advanced");
  // writes refused at full stick, flush restarts the counters, no read word is dropped
  a_ovf_sticky: assert property (
    st_reg.fifo_en && WR_EN && FULL |=> st_reg.ovf)
    else $error("refused write not flagged");
  a_flush_clears: assert property (
    REG_WR && REG_ADDR == esf_pkg::REG_CTRL && REG_WDATA[esf_pkg::CTRL_FLUSH_BIT] |=> st_reg.count == 13'h0000 && st_reg.wptr == 12'h000 && st_reg.rptr == 12'h000)
    else $error("flush left counters running");
  a_no_word_drop: assert property (
    rd_s.valid |-> rd_s.ready)
    else $error("read word arrived at a full buffer");
endmodule
`default_nettype wire

/* File: logic/esf_pkg.sv */
// shared constants and types for the embedded sram fifo block
`default_nettype none
package esf_pkg;
  localparam int unsigned MEM_BITS = 4608;
  localparam int unsigned ROW_W    = 18;
  localparam int unsigned ROW_AW   = 8;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned CNT_W    = 13;
  localparam int unsigned DATA_W   = 18;
  localparam int unsigned BUF_LVL_W = 2;
  localparam logic [1:0]  BUF_DEPTH = 2'h2;

  // port aspect codes: 4k x1, 2k x2, 1k x4, 512 x9, 256 x18
  typedef enum logic [2:0] {ESF_W1, ESF_W2, ESF_W4, ESF_W9, ESF_W18} esf_width_t;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_DEPTH     = 8'h04;
  localparam logic [7:0] REG_AE_THR    = 8'h08;
  localparam logic [7:0] REG_AF_THR    = 8'h0c;
  localparam logic [7:0] REG_STATUS    = 8'h10;
  localparam logic [7:0] REG_INIT_ADDR = 8'h14;
  localparam logic [7:0] REG_INIT_DATA = 8'h18;

  // control fields
  localparam int unsigned CTRL_FIFO_BIT  = 0;
  localparam int unsigned CTRL_WRW_LSB   = 1;
  localparam int unsigned CTRL_RDW_LSB   = 4;
  localparam int unsigned CTRL_FLUSH_BIT = 7;

  // status fields
  localparam int unsigned ST_EMPTY   = 0;
  localparam int unsigned ST_FULL    = 1;
  localparam int unsigned ST_NEAR_E  = 2;
  localparam int unsigned ST_NEAR_F  = 3;
  localparam int unsigned ST_OVF     = 4;
  localparam int unsigned ST_UNF     = 5;
  localparam int unsigned ST_CNT_LSB = 8;

  // reset values
  localparam logic [12:0] DEPTH_RST  = 13'h0100;
  localparam logic [12:0] AE_THR_RST = 13'h0004;
  localparam logic [12:0] AF_THR_RST = 13'h00fc;
endpackage
`default_nettype wire

/* File: logic/esf_stream_if.sv */
// valid/ready word stream between the block's own modules
`default_nettype none
interface esf_stream_if;
  logic        valid;
  logic        ready;
  logic [17:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: verif/esf_user_model.sv */
// user-side sink model that takes read words off the block's output
`default_nettype none
module esf_user_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        out_valid,
  input  wire logic [17:0] out_data,
  input  wire logic [1:0]  stall_mode,
  output logic             out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] got[$];
  logic        phase_reg;

  // ready pattern: 0 always, 1 never, 2 every other cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      out_ready <= (stall_mode == 2'h0) || ((stall_mode == 2'h2) && phase_reg);
    end
  end

  // a word counts only on an edge where both sides agree
  always @(posedge clk) begin
    if (rst_n && out_valid && out_ready) begin
      got.push_back(out_data);
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the sram fifo block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        wr_en = 1'b0;
  logic [11:0] wr_addr = 12'h000;
  logic [17:0] wr_data = 18'h0;
  logic        rd_en = 1'b0;
  logic [11:0] rd_addr = 12'h000;
  logic        wr_ready, rd_ready, out_valid, out_ready;
  logic [17:0] out_data;
  logic        empty, full, near_e, near_f;
  logic [3:0]  flg;
  logic [1:0]  stall = 2'h2;
  int          miscompares = 0;
  int          n_checks = 0;

  assign flg = {empty, full, near_e, near_f};
  // 100 MHz clock
  always #5 clk = ~clk;

  esf_fifo_top DUT (.CLK(clk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .WR_EN(wr_en), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .WR_READY(wr_ready), .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_READY(rd_ready),
    .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_DATA(out_data), .EMPTY(empty), .FULL(full),
    .NEAR_EMPTY_FLAG(near_e), .NEAR_FULL_FLAG(near_f));

  esf_user_model U_user (.clk(clk), .rst_n(nrst), .out_valid(out_valid), .out_data(out_data),
    .stall_mode(stall), .out_ready(out_ready));

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flags(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one-cycle register write
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_reg(what, exp, reg_rdata);
  endtask

  task automatic user_wr(input logic [11:0] a, input logic [17:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // request held until an edge where buffer room is seen
  task automatic user_rd(input logic [11:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    for (int k = 0; k < 50; k++) begin
      #1;
      if (rd_ready === 1'b1) break;
      @(posedge clk);
    end
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  // bounded wait for the sink model to take a word
  task automatic get_word(input string what, input logic [17:0] exp);
    for (int k = 0; k < 100 && U_user.got.size() == 0; k++) begin
      @(posedge clk);
      #1;
    end
    if (U_user.got.size() == 0) chk_word(what, exp, 18'hx);
    else chk_word(what, exp, U_user.got.pop_front());
  endtask

  task automatic final_report;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hang costs a mismatch; the whole run needs a few hundred cycles
  initial begin
    #100us;
    miscompares++;
    final_report;
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk_flags("ram mode flags", 4'h0, flg);
    chk_flags("readies", 4'hc, {wr_ready, rd_ready, out_valid, 1'b0});
    rd_chk("ctrl reset", esf_pkg::REG_CTRL, 32'h00000048);
    rd_chk("depth reset", esf_pkg::REG_DEPTH, {19'h0, esf_pkg::DEPTH_RST});
    rd_chk("ae reset", esf_pkg::REG_AE_THR, {19'h0, esf_pkg::AE_THR_RST});
    rd_chk("af reset", esf_pkg::REG_AF_THR, {19'h0, esf_pkg::AF_THR_RST});
    rd_chk("unmapped", 8'h20, 32'h0);
    // ram mode, full-width then mixed widths
    user_wr(12'h005, 18'h2c3a5);
    user_rd(12'h005);
    get_word("ram x18", 18'h2c3a5);
    bus_wr(esf_pkg::REG_CTRL, 32'h00000046);
    user_wr(12'h002, 18'h001ab);
    user_wr(12'h003, 18'h00055);
    user_rd(12'h001);
    get_word("x9 in x18 out", 18'h0abab);
    // preload through the test path, rows auto-increment
    bus_wr(esf_pkg::REG_INIT_ADDR, 32'h00000010);
    bus_wr(esf_pkg::REG_INIT_DATA, 32'h00012345);
    bus_wr(esf_pkg::REG_INIT_DATA, 32'h0000beef);
    user_rd(12'h010);
    get_word("preload row0", 18'h12345);
    user_rd(12'h011);
    get_word("preload row1", 18'h0beef);
    bus_wr(esf_pkg::REG_CTRL, 32'h00000038);
    user_rd(12'h020);
    get_word("x9 low half", 18'h00145);
    user_rd(12'h021);
    get_word("x9 high half", 18'h00091);
    bus_wr(esf_pkg::REG_CTRL, 32'h00000008);
    user_rd(12'h100);
    get_word("x1 bit0", 18'h00001);
    user_rd(12'h101);
    get_word("x1 bit1", 18'h00000);
    // fifo mode, depth 4, thresholds 1 and 3
    bus_wr(esf_pkg::REG_CTRL, 32'h00000049);
    bus_wr(esf_pkg::REG_DEPTH, 32'h4);
    bus_wr(esf_pkg::REG_AE_THR, 32'h1);
    bus_wr(esf_pkg::REG_AF_THR, 32'h3);
    @(posedge clk);
    #1;
    chk_flags("fifo empty", 4'ha, flg);
    for (int i = 0; i < 4; i++) begin
      user_wr(12'h000, 18'h3f000 | 18'(i));
      #1;
      chk_flags("fill flags", {1'b0, i == 3, i + 1 <= 1, i + 1 >= 3}, flg);
    end
    chk_flags("write ready when full", 4'h0, {3'h0, wr_ready});
    rd_chk("status full", esf_pkg::REG_STATUS, 32'h0000040a);
    user_wr(12'h000, 18'h3ffff);
    rd_chk("write when full", esf_pkg::REG_STATUS, 32'h0000041a);
    bus_wr(esf_pkg::REG_STATUS, 32'h00000010);
    // receiver stalls: two words fill the read buffer
    @(posedge clk);
    stall <= 2'h1;
    user_rd(12'h000);
    user_rd(12'h000);
    repeat (3) @(posedge clk);
    #1;
    chk_flags("buffer full", 4'h1, {2'h0, rd_ready, out_valid});
    rd_chk("count two", esf_pkg::REG_STATUS, 32'h00000200);
    @(posedge clk);
    stall <= 2'h2;
    user_rd(12'h000);
    user_rd(12'h000);
    for (int i = 0; i < 4; i++) begin
      get_word("fifo order", 18'h3f000 | 18'(i));
    end
    user_rd(12'h000);
    repeat (4) @(posedge clk);
    rd_chk("read when empty", esf_pkg::REG_STATUS, 32'h00000025);
    chk_flags("no stray word", 4'h0, 4'(U_user.got.size()));
    // flush drops stored words and restarts both pointers
    user_wr(12'h000, 18'h00077);
    rd_chk("one word", esf_pkg::REG_STATUS, 32'h00000124);
    bus_wr(esf_pkg::REG_CTRL, 32'h000000c9);
    bus_wr(esf_pkg::REG_STATUS, 32'h00000020);
    rd_chk("flushed", esf_pkg::REG_STATUS, 32'h00000005);
    // ram mode, nibble written and read back as two-bit words
    bus_wr(esf_pkg::REG_CTRL, 32'h00000014);
    user_wr(12'h082, 18'h3fffd);
    user_rd(12'h104);
    get_word("x4 in x2 out low", 18'h00001);
    user_rd(12'h105);
    get_word("x4 in x2 out high", 18'h00003);
    final_report;
  end
endmodule
`default_nettype wire
